// >>> verilog/kms_pkg.sv
// Purpose: Shared constants for the key matrix scanner
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Mode register sits one word below the line enables
package kms_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] KMS_MODE_OFS = 8'h0c;
  localparam logic [7:0] KMS_LINE_ENABLES_OFS = 8'h10;
  localparam logic [7:0] KMS_SCAN_RATE_DIVISOR_OFS = 8'h14;
  localparam logic [7:0] KMS_LIVE_HIT_VECTOR_OFS = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int KMS_LINES = 4;
  localparam int KMS_DIV_W = 13;
  localparam int KMS_VEC_W = 16;
  localparam int KMS_RET_LSB = 4;
  localparam int KMS_DRV_LSB = 0;
  localparam int KMS_MODE_VALUE_CLR_BIT = 0;
  localparam int KMS_MODE_AUTO_CLR_BIT = 1;
  localparam int KMS_MODE_SINGLE_BIT = 3;
  localparam int KMS_MODE_POL_BIT = 4;
  localparam int KMS_MODE_ON_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] KMS_MODE_RST = 6'h00;
  localparam logic [7:0] KMS_LINE_ENABLES_RST = 8'h00;
  localparam logic [12:0] KMS_DIV_RST = 13'h1fff;
  localparam logic [15:0] KMS_VEC_RST = 16'h0000;

  typedef enum logic [1:0] {
    KMS_IDLE,
    KMS_DRIVE,
    KMS_SAMPLE
  } kms_state_t;

endpackage : kms_pkg

// >>> verilog/kms_rate_div.sv
// Purpose: Step tick generator for the drive line sequencer
// Assumes: Divisor is sampled every cycle
// Notes: One tick every divisor+1 clocks while running
`timescale 1ns/1ps
`default_nettype none
module kms_rate_div (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic [kms_pkg::KMS_DIV_W-1:0] divisor_in,
  // Tick
  output logic tick_out
);

  logic [kms_pkg::KMS_DIV_W-1:0] count_q;

  // Counter restarts when stopped so the first step is a full interval
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !run_in)
    begin
      count_q <= '0;
      tick_out <= 1'b0;
    end
    else if (count_q >= divisor_in)
    begin
      count_q <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : kms_rate_div
`default_nettype wire

// >>> verilog/kms_scanner.sv
// Purpose: Key matrix scanner with Wishbone register access
// Assumes: Sense inputs synchronous to sys_clk_in, pulls external
// Notes: Ack one cycle after the request is seen, dropped next cycle
// How it works
// - Return line enables in bits 7..4, reset zero
// - Drive line enables in bits 3..0, reset zero
// - Step rate is clock over divisor plus one, clock over two when the divisor is zero
// - Hit vector refreshed live once per sweep, every fourth step
// - Drive s, return k lands in bit 4s+k
// - Hit vector read-only, not latched
// - Scanning only while unit on bit set
// - Polarity bit sets drive and sense level
// - Single key mode keeps one pressed key
// - Clear on read empties vector after read
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
module kms_scanner (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Matrix pins
  output logic [3:0] drive_line_out,
  output logic [3:0] drive_line_oe_out,
  input wire logic [3:0] return_line_in
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] mode_q;
  logic [7:0] line_enables_q;
  logic [12:0] divisor_q;
  logic [15:0] hit_vec_q;
  logic [15:0] scan_vec_q;
  logic [1:0] drive_idx_q;
  kms_pkg::kms_state_t state_q;
  logic tick;
  logic req;
  logic wr_hit;
  logic rd_hit;

  function automatic logic reg_sel(input logic [7:0] adr, input logic [7:0] ofs);
    reg_sel = (adr[7:2] == ofs[7:2]);
  endfunction : reg_sel

  wire logic unit_on = mode_q[kms_pkg::KMS_MODE_ON_BIT];
  wire logic pol_high = mode_q[kms_pkg::KMS_MODE_POL_BIT];
  wire logic [3:0] drv_en = line_enables_q[kms_pkg::KMS_DRV_LSB +: kms_pkg::KMS_LINES];
  wire logic [3:0] ret_en = line_enables_q[kms_pkg::KMS_RET_LSB +: kms_pkg::KMS_LINES];
  // Pressed level follows polarity
  wire logic [3:0] pressed = (pol_high ? return_line_in : ~return_line_in) & ret_en;

  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_hit = req && wb_we_in && wb_sel_in[0];
  assign rd_hit = req && !wb_we_in && reg_sel(wb_adr_in, kms_pkg::KMS_LIVE_HIT_VECTOR_OFS);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      wb_ack_out <= 1'b0;
    else
      wb_ack_out <= req;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      wb_dat_out <= 32'h0000_0000;
    else if (req && !wb_we_in)
    begin
      if (reg_sel(wb_adr_in, kms_pkg::KMS_MODE_OFS))
        wb_dat_out <= {26'h0, mode_q[5:1], 1'b0};
      else if (reg_sel(wb_adr_in, kms_pkg::KMS_LINE_ENABLES_OFS))
        wb_dat_out <= {24'h0, line_enables_q};
      else if (reg_sel(wb_adr_in, kms_pkg::KMS_SCAN_RATE_DIVISOR_OFS))
        wb_dat_out <= {19'h0, divisor_q};
      else if (reg_sel(wb_adr_in, kms_pkg::KMS_LIVE_HIT_VECTOR_OFS))
        wb_dat_out <= {16'h0, hit_vec_q};
      else
        wb_dat_out <= 32'h0000_0000;
    end
  end

  // Mode register; clear bit self-resets
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      mode_q <= kms_pkg::KMS_MODE_RST;
    else if (wr_hit && reg_sel(wb_adr_in, kms_pkg::KMS_MODE_OFS))
      mode_q <= {wb_dat_in[5:3], 1'b0, wb_dat_in[1:0]};
    else
      mode_q[kms_pkg::KMS_MODE_VALUE_CLR_BIT] <= 1'b0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      line_enables_q <= kms_pkg::KMS_LINE_ENABLES_RST;
    else if (wr_hit && reg_sel(wb_adr_in, kms_pkg::KMS_LINE_ENABLES_OFS))
      line_enables_q <= wb_dat_in[7:0];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      divisor_q <= kms_pkg::KMS_DIV_RST;
    else if (req && wb_we_in && reg_sel(wb_adr_in, kms_pkg::KMS_SCAN_RATE_DIVISOR_OFS))
    begin
      if (wb_sel_in[0])
        divisor_q[7:0] <= wb_dat_in[7:0];
      if (wb_sel_in[1])
        divisor_q[12:8] <= wb_dat_in[12:8];
    end
  end

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  kms_rate_div u_rate_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .run_in(unit_on),
    .divisor_in(divisor_q),
    .tick_out(tick)
  );

  // Each tick seen in DRIVE steps to the next drive line; a sweep spans four such ticks
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !unit_on)
    begin
      state_q <= kms_pkg::KMS_IDLE;
      drive_idx_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        kms_pkg::KMS_IDLE:
          state_q <= kms_pkg::KMS_DRIVE;
        kms_pkg::KMS_DRIVE:
          if (tick)
            state_q <= kms_pkg::KMS_SAMPLE;
        kms_pkg::KMS_SAMPLE:
        begin
          state_q <= kms_pkg::KMS_DRIVE;
          drive_idx_q <= drive_idx_q + 2'h1;
        end
        default:
          state_q <= kms_pkg::KMS_IDLE;
      endcase
    end
  end

  // Only the active, enabled drive line is driven; others float
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      drive_line_out <= 4'h0;
      drive_line_oe_out <= 4'h0;
    end
    else
    begin
      drive_line_out <= {4{~pol_high}} ^ (4'h1 << drive_idx_q);
      drive_line_oe_out <= (unit_on && state_q != kms_pkg::KMS_IDLE) ?
                           ((4'h1 << drive_idx_q) & drv_en) : 4'h0;
    end
  end

  // Sweep result; row s sits at bits 4s+3..4s
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !unit_on)
      scan_vec_q <= kms_pkg::KMS_VEC_RST;
    else if (state_q == kms_pkg::KMS_SAMPLE)
    begin
      for (int s = 0; s < kms_pkg::KMS_LINES; s++)
      begin
        if (s == int'(drive_idx_q))
          scan_vec_q[4*s +: 4] <= drv_en[s] ? pressed : 4'h0;
      end
    end
  end

  // Last row joins in its own sample cycle, else it would lag a whole sweep
  wire logic [3:0] row_now = drv_en[drive_idx_q] ? pressed : 4'h0;
  wire logic [15:0] full_vec = {row_now, scan_vec_q[11:0]};
  // Single key mode keeps only the lowest set bit
  wire logic [15:0] sweep_vec = mode_q[kms_pkg::KMS_MODE_SINGLE_BIT] ?
                                (full_vec & (~full_vec + 16'h1)) : full_vec;

  // Live vector updates at the end of each sweep; read clear wins
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      hit_vec_q <= kms_pkg::KMS_VEC_RST;
    else if (mode_q[kms_pkg::KMS_MODE_VALUE_CLR_BIT] ||
             (rd_hit && mode_q[kms_pkg::KMS_MODE_AUTO_CLR_BIT]))
      hit_vec_q <= kms_pkg::KMS_VEC_RST;
    else if (state_q == kms_pkg::KMS_SAMPLE && drive_idx_q == 2'h3)
      hit_vec_q <= sweep_vec;
    else if (!unit_on)
      hit_vec_q <= kms_pkg::KMS_VEC_RST;
  end

endmodule : kms_scanner
`default_nettype wire

// >>> testbench/kms_scanner_properties.sv
// Purpose: Port checks for kms_scanner
// Assumes: One clock, sync reset
// Notes: Bound to every scanner instance
`timescale 1ns/1ps
`default_nettype none
module kms_scanner_properties (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [3:0] drive_line_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Address of a read being answered, 8'hff otherwise
  wire logic [7:0] rd_adr = wb_ack_out && !wb_we_in ? wb_adr_in : 8'hff;
  chk_ack_late: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack long");
  chk_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("stray ack");
  chk_reset_idle: assert property (disable iff (1'b0) rst_in |=> !wb_ack_out && drive_line_oe_out == 4'h0)
    else $error("busy in reset");
  chk_one_drive: assert property ($onehot0(drive_line_oe_out)) else $error("two drives");
  chk_enable_width: assert property (rd_adr == 8'h10 |-> wb_dat_out[31:8] == 24'h0) else $error("bits");
  chk_divisor_width: assert property (rd_adr == 8'h14 |-> wb_dat_out[31:13] == 19'h0)
    else $error("bits");
  chk_vector_width: assert property (rd_adr == 8'h18 |-> wb_dat_out[31:16] == 16'h0)
    else $error("bits");
  cover property (rd_adr == 8'h18 && wb_dat_out != 32'h0);
  cover property (drive_line_oe_out != 4'h0);
  cover property (wb_ack_out && wb_we_in);
endmodule : kms_scanner_properties
bind kms_scanner kms_scanner_properties i_kms_scanner_properties (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .drive_line_oe_out(drive_line_oe_out));
`default_nettype wire

// >>> testbench/kms_key_matrix.sv
// Purpose: Key switch matrix with pull resistors
// Assumes: Test patterns have no ghost paths
// Notes: Undriven return lines sit at the pull level
`timescale 1ns/1ps
`default_nettype none
module kms_key_matrix (
  input wire logic [3:0] drive_in,
  input wire logic [3:0] oe_in,
  input wire logic [15:0] pressed_in,
  input wire logic pull_up_in,
  output logic [3:0] return_out
);
  always_comb
  begin
    return_out = {4{pull_up_in}};
    for (int i = 0; i < 16; i++)
      if (oe_in[i / 4] && pressed_in[i]) return_out[i % 4] = drive_in[i / 4];
  end
endmodule : kms_key_matrix
`default_nettype wire

// >>> testbench/kms_scanner_tb_top.sv
// Purpose: Self-checking bench for kms_scanner
// Assumes: Divisor 3, so a sweep settles within 40 clocks
// Notes: Byte enables tied on, stb follows cyc
`timescale 1ns/1ps
`default_nettype none
module kms_scanner_tb_top;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, up = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] drv, oe, ret;
  logic [15:0] keys = 16'h0;
  logic [31:0] wd = 32'h0, rdat;
  int errors = 0, cmp_count = 0;
  kms_scanner i_kms_scanner (.sys_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack),
    .drive_line_out(drv), .drive_line_oe_out(oe), .return_line_in(ret));
  kms_key_matrix i_kms_key_matrix (.drive_in(drv), .oe_in(oe), .pressed_in(keys), .pull_up_in(up),
    .return_out(ret));
  initial forever #12.5 clk = ~clk;
  task automatic complete_run;
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) errors++;
    if (g !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, g);
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, we, adr, wd} <= {1'b1, w, a, d};
    // Only ack or the watchdog ends a wait for the answer
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    if (!w) chk($sformatf("reg %h", a), d, rdat);
  endtask : wb
  task automatic settle(input logic [3:0] m);
    repeat (40) @(posedge clk) chk("oe", 32'h0, 32'(oe & ~m));
  endtask : settle
  task automatic t_registers;
    wb(1'b0, 8'h10, 32'h0);
    wb(1'b0, 8'h14, 32'h1fff);
    wb(1'b0, 8'h18, 32'h0);
    wb(1'b0, 8'h1c, 32'h0);
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'hff);
    wb(1'b1, 8'h14, 32'h3);
  endtask : t_registers
  task automatic t_key_map;
    logic [15:0] p [3] = '{16'h8001, 16'h0240, 16'h1248};
    for (int i = 0; i < 6; i++)
    begin
      up <= (i < 3);
      keys <= p[i % 3];
      wb(1'b1, 8'h0c, i < 3 ? 32'h20 : 32'h30);
      settle(4'hf);
      wb(1'b1, 8'h18, 32'hffff);
      wb(1'b0, 8'h18, 32'(p[i % 3]));
    end
  endtask : t_key_map
  task automatic t_line_masks;
    keys <= 16'h0240;
    wb(1'b1, 8'h0c, 32'h38);
    settle(4'hf);
    wb(1'b0, 8'h18, 32'h40);
    wb(1'b1, 8'h10, 32'h3c);
    keys <= 16'hffff;
    wb(1'b1, 8'h0c, 32'h30);
    settle(4'hc);
    wb(1'b0, 8'h18, 32'h3300);
  endtask : t_line_masks
  task automatic t_clear_and_off;
    wb(1'b1, 8'h0c, 32'h30);
    settle(4'hc);
    // Slow sweep, so only a clear can empty the vector
    wb(1'b1, 8'h14, 32'h1fff);
    wb(1'b0, 8'h18, 32'h3300);
    wb(1'b0, 8'h18, 32'h3300);
    wb(1'b1, 8'h0c, 32'h31);
    wb(1'b0, 8'h0c, 32'h30);
    wb(1'b0, 8'h18, 32'h0);
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h0c, 32'h32);
    settle(4'hc);
    wb(1'b1, 8'h14, 32'h1fff);
    wb(1'b0, 8'h18, 32'h3300);
    wb(1'b0, 8'h18, 32'h0);
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h0c, 32'h0);
    settle(4'h0);
    wb(1'b0, 8'h18, 32'h0);
  endtask : t_clear_and_off
  task automatic t_mid_reset;
    wb(1'b1, 8'h0c, 32'h30);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h0c, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    wb(1'b0, 8'h14, 32'h1fff);
    wb(1'b0, 8'h18, 32'h0);
    settle(4'h0);
  endtask : t_mid_reset
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_registers();
    t_key_map();
    t_line_masks();
    t_clear_and_off();
    t_mid_reset();
    complete_run();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : kms_scanner_tb_top
`default_nettype wire
